// file: rtl/dout_chan_pkg.sv
// Shared constants and carrier types for the digital output channel block
package dout_chan_pkg;

    localparam int  NCH          = 8;
    localparam int  DLY_W        = 16;
    localparam int  CLK_HZ       = 200_000_000;

    // Communication watchdog time in seconds
    localparam real WDOG_TIME_S  = 0.5;
    localparam int  WDOG_CYCLES  = int'($ceil(WDOG_TIME_S * CLK_HZ));
    localparam int  WDOG_W       = 27;

    // Delay granularity, one millisecond
    localparam real TICK_TIME_S  = 0.001;
    localparam int  TICK_CYCLES  = int'($ceil(TICK_TIME_S * CLK_HZ));
    localparam int  TICK_W       = 18;

    // Validity bit: 0 enabled, 1 invalid
    localparam logic DATA_OK     = 1'b0;
    localparam logic DATA_BAD    = 1'b1;
    localparam logic RST_OUT     = 1'b0;

    typedef enum logic [1:0] {
        ERR_CURRENT,
        ERR_SUBST,
        ERR_LAST
    } err_mode_e;

    // Value bit with companion validity bit
    typedef struct packed {
        logic value;
        logic invalid;
    } chan_data_s;

    typedef struct packed {
        logic              sim_mode;
        logic              sim_value;
        logic              sim_invalid;
        err_mode_e         err_mode;
        logic              subst_value;
        logic              negate;
        logic [DLY_W-1:0]  on_delay_ms;
        logic [DLY_W-1:0]  off_delay_ms;
    } chan_cfg_s;

endpackage : dout_chan_pkg

// file: rtl/dout_chan.sv
// Eight-channel digital output processing with watchdog and substitute values
// Function
// - No communication for 0.5 s raises the error condition on every channel.
// - Normal mode drives the received bus value.
// - Simulation mode drives the configured simulated value instead.
// - Watchdog expiry or invalid data selects the error-mode value.
// - Line faults never start substitute-value handling.
// - Current-value mode passes the value unchanged, simulated too.
// - Substitute mode drives the configured substitute bit.
// - A substitute value is always flagged invalid.
// - Last-valid mode holds the value from before the error.
// - Negation inverts the channel signal.
// - ON delay postpones rising edges, filtering short high pulses.
// - OFF delay postpones falling edges, stretching high pulses.
// - Simulated value carries OK or invalid status; invalid starts error handling.
// - Each channel value travels with a validity bit, 0 enabled, 1 invalid.
// - Actual output state, including pending delays, is returned.
`timescale 1ns/1ps
module dout_chan #(
    parameter int unsigned WDOG_CYCLES = dout_chan_pkg::WDOG_CYCLES,
    parameter int unsigned TICK_CYCLES = dout_chan_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                                         clk,
    input  wire logic                                         rst,
    // Cyclic data from the communication unit
    input  wire logic                                         xfer_stb,
    input  wire dout_chan_pkg::chan_data_s [dout_chan_pkg::NCH-1:0] bus_data,
    // Per-channel configuration
    input  wire dout_chan_pkg::chan_cfg_s  [dout_chan_pkg::NCH-1:0] cfg,
    // Field side
    input  wire logic [dout_chan_pkg::NCH-1:0]                line_fault_pin,
    output logic      [dout_chan_pkg::NCH-1:0]                dout,
    // Returned state
    output dout_chan_pkg::chan_data_s      [dout_chan_pkg::NCH-1:0] status,
    output logic      [dout_chan_pkg::NCH-1:0]                line_fault,
    output logic                                              wdog_expired
);

    localparam int NCH = dout_chan_pkg::NCH;
    localparam int DW  = dout_chan_pkg::DLY_W;

    dout_chan_pkg::chan_data_s [NCH-1:0] bus_r;
    logic [dout_chan_pkg::WDOG_W-1:0]    wd_cnt_r;
    logic                                wd_exp_r;
    logic [dout_chan_pkg::TICK_W-1:0]    tick_cnt_r;
    logic                                tick_r;
    logic [NCH-1:0]                      last_r;
    logic [NCH-1:0]                      out_r;
    logic [DW-1:0]                       dly_cnt_r [NCH];
    logic [NCH-1:0]                      lf_meta_r;
    logic [NCH-1:0]                      lf_sync_r;
    dout_chan_pkg::chan_data_s [NCH-1:0] stat_r;

    logic [NCH-1:0] src_val;
    logic [NCH-1:0] src_inv;
    logic [NCH-1:0] err;
    logic [NCH-1:0] sel;
    logic [NCH-1:0] tgt;
    logic [NCH-1:0] flip;

    function automatic logic [DW-1:0] need_dly(input dout_chan_pkg::chan_cfg_s c, input logic rising);
        need_dly = rising ? c.on_delay_ms : c.off_delay_ms;
    endfunction : need_dly

    // Bus image is held between exchanges
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NCH; i++) begin
                bus_r[i] <= '{value: 1'b0, invalid: dout_chan_pkg::DATA_BAD};
            end
        end else if (xfer_stb) begin
            bus_r <= bus_data;
        end
    end

    // Watchdog; starts expired-free, restarts on each exchange
    always_ff @(posedge clk) begin
        if (rst) begin
            wd_cnt_r <= '0;
            wd_exp_r <= 1'b0;
        end else if (xfer_stb) begin
            wd_cnt_r <= '0;
            wd_exp_r <= 1'b0;
        end else if (wd_cnt_r == dout_chan_pkg::WDOG_W'(WDOG_CYCLES - 1)) begin
            wd_exp_r <= 1'b1;
        end else begin
            wd_cnt_r <= wd_cnt_r + 1'b1;
        end
    end

    // Millisecond tick for the delays
    always_ff @(posedge clk) begin
        if (rst) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == dout_chan_pkg::TICK_W'(TICK_CYCLES - 1)) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
            tick_r     <= 1'b0;
        end
    end

    // Source, error and strategy selection
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            src_val[i] = cfg[i].sim_mode ? cfg[i].sim_value : bus_r[i].value;
            src_inv[i] = cfg[i].sim_mode ? cfg[i].sim_invalid : bus_r[i].invalid;
            // Line fault state is deliberately absent from this term
            err[i] = wd_exp_r | (src_inv[i] == dout_chan_pkg::DATA_BAD);
            case (cfg[i].err_mode)
                dout_chan_pkg::ERR_CURRENT: sel[i] = src_val[i];
                dout_chan_pkg::ERR_SUBST:   sel[i] = err[i] ? cfg[i].subst_value : src_val[i];
                dout_chan_pkg::ERR_LAST:    sel[i] = err[i] ? last_r[i] : src_val[i];
                default:                    sel[i] = src_val[i];
            endcase
            tgt[i]  = sel[i] ^ cfg[i].negate;
            flip[i] = (tgt[i] != out_r[i]) && (dly_cnt_r[i] >= need_dly(cfg[i], tgt[i]));
        end
    end

    // Last valid value, frozen while the error lasts
    always_ff @(posedge clk) begin
        if (rst) begin
            last_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (!err[i]) begin
                    last_r[i] <= src_val[i];
                end
            end
        end
    end

    // ON/OFF delay: a pending edge waits for the matching number of ticks
    always_ff @(posedge clk) begin
        if (rst) begin
            out_r <= {NCH{dout_chan_pkg::RST_OUT}};
            for (int i = 0; i < NCH; i++) begin
                dly_cnt_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (tgt[i] == out_r[i] || flip[i]) begin
                    dly_cnt_r[i] <= '0;
                end else if (tick_r && dly_cnt_r[i] != '1) begin
                    dly_cnt_r[i] <= dly_cnt_r[i] + 1'b1;
                end
                if (flip[i]) begin
                    out_r[i] <= tgt[i];
                end
            end
        end
    end

    // Returned state: actual output plus validity of the driving data
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NCH; i++) begin
                stat_r[i] <= '{value: dout_chan_pkg::RST_OUT, invalid: dout_chan_pkg::DATA_BAD};
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                stat_r[i].value   <= out_r[i];
                // Substitute and held values are only ever used during an error
                stat_r[i].invalid <= err[i];
            end
        end
    end

    // Line fault pin is reported only
    always_ff @(posedge clk) begin
        if (rst) begin
            lf_meta_r <= '0;
            lf_sync_r <= '0;
        end else begin
            lf_meta_r <= line_fault_pin;
            lf_sync_r <= lf_meta_r;
        end
    end

    assign dout         = out_r;
    assign status       = stat_r;
    assign line_fault   = lf_sync_r;
    assign wdog_expired = wd_exp_r;

    // Checks
    property p_wdog_trip;
        @(posedge clk) disable iff (rst)
        (wd_cnt_r == dout_chan_pkg::WDOG_W'(WDOG_CYCLES - 1)) && !xfer_stb |=> wd_exp_r;
    endproperty
    a_wdog_trip: assert property (p_wdog_trip) else $error("watchdog did not expire");

    property p_wdog_early;
        @(posedge clk) disable iff (rst)
        !wd_exp_r && (wd_cnt_r < dout_chan_pkg::WDOG_W'(WDOG_CYCLES - 1)) |=> !wd_exp_r || $past(wd_exp_r);
    endproperty
    a_wdog_early: assert property (p_wdog_early) else $error("watchdog expired early");

    property p_wdog_release;
        @(posedge clk) disable iff (rst)
        xfer_stb |=> !wd_exp_r && wd_cnt_r == '0;
    endproperty
    a_wdog_release: assert property (p_wdog_release) else $error("exchange did not restart watchdog");

    for (genvar g = 0; g < NCH; g++) begin : g_chk
        property p_normal;
            @(posedge clk) disable iff (rst)
            !cfg[g].sim_mode && !err[g] |-> sel[g] == bus_r[g].value;
        endproperty
        a_normal: assert property (p_normal) else $error("bus value not driven");

        property p_sim;
            @(posedge clk) disable iff (rst)
            cfg[g].sim_mode |-> src_val[g] == cfg[g].sim_value && src_inv[g] == cfg[g].sim_invalid;
        endproperty
        a_sim: assert property (p_sim) else $error("simulated value not used");

        property p_sim_bad;
            @(posedge clk) disable iff (rst)
            cfg[g].sim_mode && cfg[g].sim_invalid |-> err[g];
        endproperty
        a_sim_bad: assert property (p_sim_bad) else $error("invalid simulation did not raise error");

        property p_current;
            @(posedge clk) disable iff (rst)
            cfg[g].err_mode == dout_chan_pkg::ERR_CURRENT
                |-> sel[g] == (cfg[g].sim_mode ? cfg[g].sim_value : bus_r[g].value);
        endproperty
        a_current: assert property (p_current) else $error("current value altered");

        property p_subst;
            @(posedge clk) disable iff (rst)
            err[g] && cfg[g].err_mode == dout_chan_pkg::ERR_SUBST |-> sel[g] == cfg[g].subst_value;
        endproperty
        a_subst: assert property (p_subst) else $error("substitute value not selected");

        property p_subst_flag;
            @(posedge clk) disable iff (rst)
            err[g] && cfg[g].err_mode == dout_chan_pkg::ERR_SUBST |=> stat_r[g].invalid;
        endproperty
        a_subst_flag: assert property (p_subst_flag) else $error("substitute not flagged invalid");

        property p_last;
            @(posedge clk) disable iff (rst)
            err[g] |=> last_r[g] == $past(last_r[g]);
        endproperty
        a_last: assert property (p_last) else $error("last valid value changed during error");

        property p_neg;
            @(posedge clk) disable iff (rst)
            !err[g] && !cfg[g].sim_mode |-> tgt[g] == (bus_r[g].value ^ cfg[g].negate);
        endproperty
        a_neg: assert property (p_neg) else $error("negation wrong");

        sequence s_rise_wait;
            !out_r[g] && tgt[g] && dly_cnt_r[g] < cfg[g].on_delay_ms;
        endsequence
        property p_on_dly;
            @(posedge clk) disable iff (rst)
            s_rise_wait |=> !out_r[g];
        endproperty
        a_on_dly: assert property (p_on_dly) else $error("rising edge not delayed");

        sequence s_fall_wait;
            out_r[g] && !tgt[g] && dly_cnt_r[g] < cfg[g].off_delay_ms;
        endsequence
        property p_off_dly;
            @(posedge clk) disable iff (rst)
            s_fall_wait |=> out_r[g];
        endproperty
        a_off_dly: assert property (p_off_dly) else $error("falling edge not delayed");

        property p_status;
            @(posedge clk) disable iff (rst)
            ##1 stat_r[g].value == $past(out_r[g]);
        endproperty
        a_status: assert property (p_status) else $error("returned state differs from output");
    end

endmodule : dout_chan

// file: sim/comm_unit_model.sv
// Communication unit model sending periodic cyclic exchanges
`timescale 1ns/1ps
module comm_unit_model #(
    parameter int GAP = 20
) (
    // Clock and reset
    input  wire logic                                               clk,
    input  wire logic                                               rst,
    // Control from the bench
    input  wire logic                                               run,
    input  wire dout_chan_pkg::chan_data_s [dout_chan_pkg::NCH-1:0] img,
    // Exchange towards the module
    output logic                                                    xfer_stb,
    output dout_chan_pkg::chan_data_s      [dout_chan_pkg::NCH-1:0] bus_data
);
    int cnt = 0;

    initial begin
        xfer_stb = 1'b0;
        bus_data = '1;
    end

    always @(posedge clk) begin
        #1;
        // Outside a frame the data is not held, so a late sample shows garbage
        if (xfer_stb) begin
            bus_data = ~bus_data;
        end
        if (rst || !run) begin
            cnt      = 0;
            xfer_stb = 1'b0;
        end else if (++cnt >= GAP) begin
            cnt      = 0;
            xfer_stb = 1'b1;
            bus_data = img;
        end else begin
            xfer_stb = 1'b0;
        end
    end
endmodule : comm_unit_model

// file: sim/test_output_channel_fault_strategy.sv
// Self-checking bench for the output channel fault strategy block
`timescale 1ns/1ps
module test_output_channel_fault_strategy;
    localparam int N  = dout_chan_pkg::NCH;
    localparam int WD = 200;

    logic                                  clk = 1'b0;
    logic                                  rst = 1'b1;
    logic                                  run = 1'b0;
    logic                                  xfer_stb;
    logic                                  wdog_expired;
    logic [N-1:0]                          lf_pin = '0;
    logic [N-1:0]                          line_fault;
    logic [N-1:0]                          dout;
    logic [N-1:0]                          last_ok = '0;
    logic                                  seen_hi;
    dout_chan_pkg::chan_data_s [N-1:0]     img = '1;
    dout_chan_pkg::chan_data_s [N-1:0]     bus_data;
    dout_chan_pkg::chan_data_s [N-1:0]     status;
    dout_chan_pkg::chan_cfg_s  [N-1:0]     cfg = '0;
    int                                    failures = 0;
    int                                    n_checks = 0;
    int                                    cycles = 0;

    always #2.5 clk = ~clk;

    comm_unit_model #(.GAP(20)) partner (.clk(clk), .rst(rst), .run(run), .img(img),
        .xfer_stb(xfer_stb), .bus_data(bus_data));

    dout_chan #(.WDOG_CYCLES(WD), .TICK_CYCLES(10)) DUT (.clk(clk), .rst(rst), .xfer_stb(xfer_stb),
        .bus_data(bus_data), .cfg(cfg), .line_fault_pin(lf_pin), .dout(dout), .status(status),
        .line_fault(line_fault), .wdog_expired(wdog_expired));

    // Steady-state value and error flag of one channel; tracks the last valid value
    function automatic logic [1:0] expect_ch(int i, logic wd, dout_chan_pkg::chan_data_s [N-1:0] im);
        logic v;
        logic e;
        v = cfg[i].sim_mode ? cfg[i].sim_value : im[i].value;
        e = wd | (cfg[i].sim_mode ? cfg[i].sim_invalid : im[i].invalid);
        if (e && cfg[i].err_mode == dout_chan_pkg::ERR_SUBST) v = cfg[i].subst_value;
        if (e && cfg[i].err_mode == dout_chan_pkg::ERR_LAST) v = last_ok[i];
        if (!e) last_ok[i] = v;
        return {v ^ cfg[i].negate, e};
    endfunction : expect_ch

    task automatic check(logic [15:0] seen, logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic chk_all(logic wd);
        logic [1:0] e;
        for (int i = 0; i < N; i++) begin
            e = expect_ch(i, wd, img);
            check(16'(dout[i]), 16'(e[1]));
            check(16'(status[i]), 16'(e));
        end
    endtask : chk_all

    task automatic report_and_stop();
        $display("Checks made %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            failures++;
            report_and_stop();
        end
    end

    initial begin
        dout_chan_pkg::chan_data_s [N-1:0] old;
        void'($urandom(86));
        // Expected image before any exchange matches the reset bus image
        for (int i = 0; i < N; i++) begin
            img[i] = '{value: 1'b0, invalid: dout_chan_pkg::DATA_BAD};
        end
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        // Bus image starts invalid until the first exchange
        repeat (3) @(posedge clk);
        #1 chk_all(1'b0);
        run = 1'b1;
        for (int k = 0; k < 40; k++) begin
            @(posedge clk iff xfer_stb);
            #1 old = img;
            for (int i = 0; i < N; i++) begin
                cfg[i] = '{1'($urandom_range(1)), 1'($urandom_range(1)), 1'($urandom_range(1)),
                           dout_chan_pkg::err_mode_e'($urandom_range(2)), 1'($urandom_range(1)),
                           1'($urandom_range(1)), 16'h0000, 16'h0000};
                img[i] = dout_chan_pkg::chan_data_s'(2'($urandom_range(3)));
                void'(expect_ch(i, 1'b0, old));
            end
            lf_pin = N'($urandom);
            @(posedge clk iff xfer_stb);
            repeat (6) @(posedge clk);
            #1 chk_all(1'b0);
            check(16'(line_fault), 16'(lf_pin));
        end
        // Communication loss
        @(posedge clk iff xfer_stb);
        #1 run = 1'b0;
        repeat (WD - 10) @(posedge clk);
        #1 check(16'(wdog_expired), 16'h0000);
        repeat (20) @(posedge clk);
        #1 check(16'(wdog_expired), 16'h0001);
        chk_all(1'b1);
        run = 1'b1;
        @(posedge clk iff xfer_stb);
        repeat (3) @(posedge clk);
        #1 check(16'(wdog_expired), 16'h0000);
        // Delays on channel 0, one tick is ten cycles
        cfg[0] = '0;
        cfg[0].on_delay_ms = 16'h0005;
        cfg[0].off_delay_ms = 16'h0005;
        img[0] = '0;
        repeat (80) @(posedge clk);
        @(posedge clk iff xfer_stb);
        #1 img[0].value = 1'b1;
        @(posedge clk iff xfer_stb);
        #1 img[0].value = 1'b0;
        seen_hi = 1'b0;
        repeat (80) begin
            @(posedge clk);
            #1 seen_hi |= dout[0];
        end
        check(16'(seen_hi), 16'h0000);
        img[0].value = 1'b1;
        @(posedge clk iff xfer_stb);
        repeat (30) @(posedge clk);
        #1 check(16'(dout[0]), 16'h0000);
        check(16'(status[0].value), 16'h0000);
        repeat (30) @(posedge clk);
        #1 check(16'(dout[0]), 16'h0001);
        check(16'(status[0].value), 16'h0001);
        img[0].value = 1'b0;
        @(posedge clk iff xfer_stb);
        repeat (30) @(posedge clk);
        #1 check(16'(dout[0]), 16'h0001);
        repeat (30) @(posedge clk);
        #1 check(16'(dout[0]), 16'h0000);
        report_and_stop();
    end
endmodule : test_output_channel_fault_strategy
